// ===== hdl/smba_defs.svh
/*
 smba_defs.svh: register offsets, field positions, fixed addresses and timing
 counts of the smbus slave with alert response.
 assumes a 200 MHz hclk and a 32-bit ahb-lite register bus.
*/
`ifndef SMBA_DEFS_SVH
`define SMBA_DEFS_SVH

`define SMBA_OFS_CTRL      8'h00
`define SMBA_OFS_STATUS    8'h04
`define SMBA_OFS_TXDATA    8'h08
`define SMBA_OFS_RXCMD     8'h0C

`define SMBA_CTRL_ALERT_EN 0
`define SMBA_ST_COMM       0
`define SMBA_ST_DATA       1
`define SMBA_ST_ALERT      2
`define SMBA_ST_BUSY       3
`define SMBA_ST_ADDR_LSB   8
`define SMBA_RX_VALID      31

`define SMBA_ADDR_BASE     7'h6A
`define SMBA_ADDR_FACTORY  7'h34
`define SMBA_ADDR_ARA      7'h0C
`define SMBA_ARA_LSB       1'h1
`define SMBA_FILL_BYTE     8'hFF

`define SMBA_CLK_NS        5
`define SMBA_TIMEOUT_NS    25000000
`define SMBA_TIMEOUT_CYC   (`SMBA_TIMEOUT_NS / `SMBA_CLK_NS)

`endif

// ===== hdl/smba_pkg.sv
/*
 smba_pkg: types of the smbus slave with alert response.
 assumes nothing beyond a systemverilog compiler.
*/
package smba_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_IGN, S_ADDR, S_ACK, S_RX, S_TX, S_HACK, S_ARA
  } smba_state_t;
endpackage : smba_pkg

// ===== hdl/smba_sync.sv
/*
 smba_sync: two flip-flop synchroniser for a vector of pin levels.
 assumes each bit is a slow level or a link clock far below hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module smba_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= INIT[i];
          q[i]    <= INIT[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule : smba_sync
`default_nettype wire

// ===== hdl/smba_slave.sv
/*
 smba_slave: smbus/pmbus slave front end with strap address, factory address,
 group command deferral and alert response arbitration, ahb-lite registers.
 assumes scl and sda are open-drain wires resolved outside, far slower than hclk.
*/
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smba_defs.svh"
module smba_slave #(
  parameter int unsigned TIMEOUT_CYCLES = `SMBA_TIMEOUT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             alert_out,
  output logic             alert_oe,
  input  wire logic        addr_strap_low,
  input  wire logic        addr_strap_high,
  input  wire logic        fault_in,
  output logic             cmd_exec
);
  logic [3:0]  sync_q;
  logic        scl_s, sda_s, scl_d, sda_d;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  logic [1:0]  strap_cnt;
  logic        strap_done;
  logic [6:0]  own_addr;
  smba_pkg::smba_state_t state, after;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg, txb, cmd_r, lo_r, hi_r;
  logic [1:0]  nbytes, rd_idx;
  logic        have_cmd, frame_rd, bad;
  logic        pend_v;
  logic [7:0]  pend_cmd, pend_lo, pend_hi, rx_cmd, rx_lo, rx_hi;
  logic [1:0]  pend_n, rx_n;
  logic        rx_valid;
  logic [23:0] tmo_cnt;
  logic        tmo_hit;
  logic        alert_en, comm_fault, data_fault;
  logic [15:0] tx_word;
  logic        addr_done, hit, ev_mid, ev_badrd, ev_overrd, ev_overrx;
  logic        fault_any, ara_win, wr_ok;
  logic        take, rd_pend, wr_pend;
  logic [7:0]  rd_addr, wr_addr;
  logic [31:0] rd_mux;
  logic [7:0]  next_txb;

  function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] own,
                                    input logic alrt);
    if (alrt)
      addr_hit = (b[7:1] == `SMBA_ADDR_ARA) && b[0];
    else
      addr_hit = (b[7:1] == own) || (b[7:1] == `SMBA_ADDR_FACTORY);
  endfunction : addr_hit

  function automatic logic [7:0] tx_pick(input logic [1:0] idx, input logic [15:0] w);
    unique case (idx)
      2'h0:    tx_pick = w[7:0];
      2'h1:    tx_pick = w[15:8];
      default: tx_pick = `SMBA_FILL_BYTE;
    endcase
  endfunction : tx_pick

  smba_sync #(.WIDTH(4), .INIT(4'h3)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({addr_strap_high, addr_strap_low, sda_in, scl_in}),
    .q     (sync_q)
  );
  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  // straps are caught after the synchroniser has filled, never under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'h0;
      own_addr   <= 7'h00;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h3) begin
        own_addr   <= `SMBA_ADDR_BASE + {5'h00, sync_q[3], sync_q[2]};
        strap_done <= 1'h1;
      end
    end
  end

  assign addr_done = (state == smba_pkg::S_ADDR) && scl_fall && (bitcnt == 4'h8);
  assign hit       = addr_hit(shreg, own_addr, alert_oe) && strap_done;
  // a stop or repeated start brings its own scl rise, so one counted bit is no cut byte
  assign ev_mid    = (start_ev || stop_ev) && (bitcnt > 4'h1) && (bitcnt != 4'h8) &&
                     (state inside {smba_pkg::S_ADDR, smba_pkg::S_RX,
                                    smba_pkg::S_TX, smba_pkg::S_ARA});
  assign ev_badrd  = addr_done && hit && !alert_oe && shreg[0] && !have_cmd;
  assign ev_overrd = (state == smba_pkg::S_HACK) && scl_fall && (rd_idx != 2'h0);
  assign ev_overrx = (state == smba_pkg::S_RX) && scl_fall && (bitcnt == 4'h8) &&
                     (nbytes == 2'h3);
  assign fault_any = ev_mid || ev_badrd || ev_overrd || ev_overrx || fault_in;
  assign ara_win   = (state == smba_pkg::S_ARA) && scl_rise && (bitcnt == 4'h7) &&
                     !(!sda_oe && !sda_s);
  assign wr_ok     = !frame_rd && (nbytes != 2'h0) && !bad;
  assign next_txb  = tx_pick((rd_idx == 2'h2) ? 2'h2 : rd_idx + 2'h1, tx_word);

  // timeout counts only while a frame is open and scl is held low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tmo_cnt <= 24'h000000;
    else if (scl_s || state == smba_pkg::S_IDLE || tmo_hit)
      tmo_cnt <= 24'h000000;
    else
      tmo_cnt <= tmo_cnt + 24'h000001;
  end
  assign tmo_hit = (tmo_cnt == 24'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= smba_pkg::S_IDLE;
      after    <= smba_pkg::S_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      txb      <= 8'h00;
      sda_oe   <= 1'h0;
      nbytes   <= 2'h0;
      rd_idx   <= 2'h0;
      cmd_r    <= 8'h00;
      lo_r     <= 8'h00;
      hi_r     <= 8'h00;
      have_cmd <= 1'h0;
      frame_rd <= 1'h0;
      bad      <= 1'h0;
    end else if (tmo_hit) begin
      state    <= smba_pkg::S_IDLE;
      sda_oe   <= 1'h0;
      have_cmd <= 1'h0;
      nbytes   <= 2'h0; // an abandoned write must not run at a later stop
      frame_rd <= 1'h0;
    end else if (start_ev) begin
      state  <= smba_pkg::S_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'h0;
      nbytes <= 2'h0;
      bad    <= 1'h0;
      if (state == smba_pkg::S_IDLE || ev_mid) begin
        have_cmd <= 1'h0;
        frame_rd <= 1'h0;
      end
    end else if (stop_ev) begin
      state    <= smba_pkg::S_IDLE;
      nbytes   <= 2'h0; // a second stop must not replay the last write
      sda_oe   <= 1'h0;
      have_cmd <= 1'h0;
      frame_rd <= 1'h0;
    end else begin
      unique case (state)
        smba_pkg::S_IDLE, smba_pkg::S_IGN: begin
        end
        smba_pkg::S_ADDR: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (addr_done) begin
            bitcnt <= 4'h0;
            if (hit) begin
              sda_oe <= 1'h1;
              state  <= smba_pkg::S_ACK;
              if (alert_oe) begin
                after <= smba_pkg::S_ARA;
                txb   <= {own_addr, `SMBA_ARA_LSB};
              end else if (shreg[0]) begin
                after    <= smba_pkg::S_TX;
                frame_rd <= 1'h1;
                rd_idx   <= have_cmd ? 2'h0 : 2'h2;
                txb      <= tx_pick(have_cmd ? 2'h0 : 2'h2, tx_word);
              end else begin
                after <= smba_pkg::S_RX;
              end
            end else begin
              state <= smba_pkg::S_IGN;
            end
          end
        end
        smba_pkg::S_ACK: begin
          if (scl_fall) begin
            state  <= after;
            sda_oe <= (after == smba_pkg::S_RX) ? 1'h0 : ~txb[7];
          end
        end
        smba_pkg::S_RX: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            sda_oe <= 1'h1;
            state  <= smba_pkg::S_ACK;
            after  <= smba_pkg::S_RX;
            unique case (nbytes)
              2'h0:    cmd_r <= shreg;
              2'h1:    lo_r  <= shreg;
              2'h2:    hi_r  <= shreg;
              default: bad   <= 1'h1;
            endcase
            if (nbytes == 2'h0)
              have_cmd <= 1'h1;
            if (nbytes != 2'h3)
              nbytes <= nbytes + 2'h1;
          end
        end
        smba_pkg::S_TX, smba_pkg::S_ARA: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
            if (state == smba_pkg::S_ARA && !sda_oe && !sda_s)
              state <= smba_pkg::S_IGN;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe <= 1'h0;
              bitcnt <= 4'h0;
              state  <= (state == smba_pkg::S_TX) ? smba_pkg::S_HACK : smba_pkg::S_IGN;
            end else begin
              sda_oe <= ~txb[6];
              txb    <= {txb[6:0], 1'h1};
            end
          end
        end
        smba_pkg::S_HACK: begin
          if (scl_rise && sda_s) begin
            state <= smba_pkg::S_IGN;
          end else if (scl_fall) begin
            rd_idx <= (rd_idx == 2'h2) ? 2'h2 : rd_idx + 2'h1;
            txb    <= next_txb;
            sda_oe <= ~next_txb[7];
            state  <= smba_pkg::S_TX;
          end
        end
      endcase
    end
  end

  // a finished write parks at a repeated start and only runs at stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_v   <= 1'h0;
      pend_cmd <= 8'h00;
      pend_lo  <= 8'h00;
      pend_hi  <= 8'h00;
      pend_n   <= 2'h0;
      rx_cmd   <= 8'h00;
      rx_lo    <= 8'h00;
      rx_hi    <= 8'h00;
      rx_n     <= 2'h0;
      cmd_exec <= 1'h0;
    end else begin
      cmd_exec <= 1'h0;
      if (tmo_hit || ev_mid) begin
        pend_v <= 1'h0;
      end else if (stop_ev) begin
        pend_v <= 1'h0;
        if (wr_ok || pend_v) begin
          rx_cmd   <= wr_ok ? cmd_r : pend_cmd;
          rx_lo    <= wr_ok ? lo_r : pend_lo;
          rx_hi    <= wr_ok ? hi_r : pend_hi;
          rx_n     <= wr_ok ? nbytes : pend_n;
          cmd_exec <= 1'h1;
        end
      end else if (start_ev && wr_ok) begin
        pend_v   <= 1'h1;
        pend_cmd <= cmd_r;
        pend_lo  <= lo_r;
        pend_hi  <= hi_r;
        pend_n   <= nbytes;
      end else if (addr_done && hit && shreg[0] && !alert_oe) begin
        pend_v <= 1'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_oe <= 1'h0;
    end else if (!alert_en) begin
      alert_oe <= 1'h0;
    end else if (fault_any) begin
      alert_oe <= 1'h1;
    end else if (ara_win) begin
      alert_oe <= 1'h0;
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_out   <= 1'h0;
      alert_out <= 1'h0;
    end else begin
      sda_out   <= 1'h0;
      alert_out <= 1'h0;
    end
  end

  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
      hrdata    <= 32'h00000000;
      rd_pend   <= 1'h0;
      wr_pend   <= 1'h0;
      rd_addr   <= 8'h00;
      wr_addr   <= 8'h00;
    end else begin
      hresp     <= 1'h0;
      rd_pend   <= take && !hwrite;
      wr_pend   <= take && hwrite;
      hreadyout <= !(take && !hwrite);
      if (take)
        rd_addr <= haddr[7:0];
      if (take)
        wr_addr <= haddr[7:0];
      if (rd_pend)
        hrdata <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (rd_addr)
      `SMBA_OFS_CTRL:   rd_mux[`SMBA_CTRL_ALERT_EN] = alert_en;
      `SMBA_OFS_STATUS: begin
        rd_mux[`SMBA_ST_COMM]  = comm_fault;
        rd_mux[`SMBA_ST_DATA]  = data_fault;
        rd_mux[`SMBA_ST_ALERT] = alert_oe;
        rd_mux[`SMBA_ST_BUSY]  = (state != smba_pkg::S_IDLE);
        rd_mux[`SMBA_ST_ADDR_LSB +: 7] = own_addr;
      end
      `SMBA_OFS_TXDATA: rd_mux[15:0] = tx_word;
      `SMBA_OFS_RXCMD:  begin
        rd_mux[23:0] = {rx_hi, rx_lo, rx_cmd};
        rd_mux[25:24] = rx_n;
        rd_mux[`SMBA_RX_VALID] = rx_valid;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_en <= 1'h0;
      tx_word  <= 16'h0000;
    end else if (wr_pend) begin
      if (wr_addr == `SMBA_OFS_CTRL)
        alert_en <= hwdata[`SMBA_CTRL_ALERT_EN];
      if (wr_addr == `SMBA_OFS_TXDATA)
        tx_word <= hwdata[15:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comm_fault <= 1'h0;
      data_fault <= 1'h0;
      rx_valid   <= 1'h0;
    end else begin
      comm_fault <= ev_mid || (comm_fault &&
                    !(wr_pend && wr_addr == `SMBA_OFS_STATUS && hwdata[`SMBA_ST_COMM]));
      data_fault <= ev_mid || ev_badrd || ev_overrd || ev_overrx || (data_fault &&
                    !(wr_pend && wr_addr == `SMBA_OFS_STATUS && hwdata[`SMBA_ST_DATA]));
      rx_valid   <= cmd_exec || (rx_valid &&
                    !(wr_pend && wr_addr == `SMBA_OFS_RXCMD && hwdata[`SMBA_RX_VALID]));
    end
  end

  property p_strap;
    @(posedge hclk) disable iff (!hresetn) strap_done && $past(strap_done) |-> $stable(own_addr);
  endproperty
  a_strap: assert property (p_strap) else $error("own address changed after strap");
  property p_factory;
    @(posedge hclk) disable iff (!hresetn)
      addr_done && strap_done && !alert_oe && shreg == {`SMBA_ADDR_FACTORY, 1'h0}
      |=> state == smba_pkg::S_ACK && sda_oe;
  endproperty
  a_factory: assert property (p_factory) else $error("factory address not acked");
  property p_ack;
    @(posedge hclk) disable iff (!hresetn) addr_done && hit |=> sda_oe ##1 sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("matching address not acked");
  property p_nogc;
    @(posedge hclk) disable iff (!hresetn) addr_done && shreg == 8'h00 |=> !sda_oe;
  endproperty
  a_nogc: assert property (p_nogc) else $error("general call acked");
  property p_ara_only;
    @(posedge hclk) disable iff (!hresetn)
      addr_done && alert_oe && shreg[7:1] == own_addr |=> state == smba_pkg::S_IGN;
  endproperty
  a_ara_only: assert property (p_ara_only) else $error("own address served in alert");
  property p_alert_set;
    @(posedge hclk) disable iff (!hresetn) alert_en && fault_in ##1 alert_en |-> alert_oe;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("fault did not raise alert");
  property p_arb;
    @(posedge hclk) disable iff (!hresetn)
      state == smba_pkg::S_ARA && scl_rise && !sda_oe && !sda_s && !start_ev && !stop_ev
      |=> state == smba_pkg::S_IGN && !sda_oe;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss not taken");
  property p_win;
    @(posedge hclk) disable iff (!hresetn) ara_win && !fault_any |=> !alert_oe;
  endproperty
  a_win: assert property (p_win) else $error("alert kept after winning");
  property p_mid;
    @(posedge hclk) disable iff (!hresetn) ev_mid |=> comm_fault && data_fault && !cmd_exec;
  endproperty
  a_mid: assert property (p_mid) else $error("short byte not flagged");
  property p_tmo;
    @(posedge hclk) disable iff (!hresetn)
      tmo_hit |=> state == smba_pkg::S_IDLE && !sda_oe && !cmd_exec;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not reset link");
  property p_relax;
    @(posedge hclk) disable iff (!hresetn) !alert_en |=> !alert_oe;
  endproperty
  a_relax: assert property (p_relax) else $error("alert driven while disabled");
  property p_drv;
    @(posedge hclk) disable iff (!hresetn) $rose(sda_oe) |-> !scl_s;
  endproperty
  a_drv: assert property (p_drv) else $error("sda driven while scl high");
  property p_exec;
    @(posedge hclk) disable iff (!hresetn) cmd_exec |-> $past(stop_ev);
  endproperty
  a_exec: assert property (p_exec) else $error("command ran before stop");

  c_win:  cover property (@(posedge hclk) disable iff (!hresetn) ara_win);
  c_exec: cover property (@(posedge hclk) disable iff (!hresetn) stop_ev && pend_v);
  c_mid:  cover property (@(posedge hclk) disable iff (!hresetn) ev_mid);
  c_rd:   cover property (@(posedge hclk) disable iff (!hresetn)
                          state == smba_pkg::S_HACK && rd_idx == 2'h1 && scl_rise && sda_s);
endmodule : smba_slave
`default_nettype wire

// ===== tb/smba_host_model.sv
/*
 smba_host_model: behavioural smbus host, bit by bit, 64 ns scl period.
 assumes sda is resolved outside with a pull-up; scl stands high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module smba_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // data only moves while scl is low, so it never looks like start or stop
  task automatic bit_io(input logic tx, output logic rx);
    scl = 1'b0;
    #16 sda_pull = ~tx;
    #16 scl = 1'b1;
    #16 rx = sda;
    #16;
  endtask : bit_io
  task automatic start(input logic rep);
    if (rep) begin
      scl = 1'b0;
      #16 sda_pull = 1'b0;
      #16 scl = 1'b1;
    end
    #32 sda_pull = 1'b1;
    #32;
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b0;
    #32;
  endtask : stop
  // holding scl low past the slave's timeout abandons the frame
  task automatic hold_low(input int t);
    scl = 1'b0;
    #t scl = 1'b1;
    #32;
  endtask : hold_low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask : rbyte
endmodule : smba_host_model
`default_nettype wire

// ===== tb/smba_slave_tb.sv
/*
 smba_slave_tb: drives the smbus slave over ahb-lite and through a host model.
 assumes a pull-up on sda and the short timeout parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smba_defs.svh"
module smba_slave_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sda_out, sda_oe;
  logic        alert_out, alert_oe, cmd_exec, strap_lo, strap_hi, fault_in;
  logic        scl, host_pull, a, x;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  b;
  logic [6:0]  own;
  logic [6:0]  adr [3] = '{7'h34, 7'h00, 7'h50};
  int          failures, num_checks;
  int          n_exec = 0;
  wire logic   sda_w = ~(host_pull | sda_oe);

  smba_slave #(.TIMEOUT_CYCLES(2000)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .addr_strap_low(strap_lo),
    .addr_strap_high(strap_hi), .fault_in(fault_in), .cmd_exec(cmd_exec));
  smba_host_model h (.scl(scl), .sda_pull(host_pull), .sda(sda_w));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (cmd_exec === 1'b1)
      n_exec <= n_exec + 1;
  end
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check
  // hready is looked at on the falling edge, half a cycle after the rising edge, where the registered value is settled
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: bus wait timed out", $time);
      close_out();
    end
    @(posedge hclk);
  endtask : wait_rdy
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
  endtask : ahb
  task automatic smb_wr(input logic [6:0] ad, input int n, input logic [23:0] d,
                        output logic ok);
    logic k;
    h.start(1'b0);
    h.wbyte({ad, 1'b0}, ok);
    for (int i = 0; i < n; i++) begin
      h.wbyte(d[8*i +: 8], k);
      ok = ok & k;
    end
    h.stop();
  endtask : smb_wr

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, fault_in} = '0;
    {strap_lo, strap_hi, failures, num_checks} = '0;
    hsize = 3'h2;
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      hresetn <= 1'b0;
      {strap_hi, strap_lo} <= i[1:0];
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      ahb(1'b0, `SMBA_OFS_STATUS, 32'h0);
      check({25'h0, r[14:8]}, 32'h6A + i, "strap address");
    end
    {strap_hi, strap_lo} <= 2'b00;
    repeat (4) @(posedge hclk);
    ahb(1'b0, `SMBA_OFS_STATUS, 32'h0);
    check({25'h0, r[14:8]}, 32'h6D, "strap read once");
    own = 7'h6D;
    $display("test straps done");
    for (int n = 1; n <= 3; n++) begin
      smb_wr(own, n, 24'hC35A96, a);
      check(a, 1'b1, "write acks");
      ahb(1'b0, `SMBA_OFS_RXCMD, 32'h0);
      check(r & (32'h83000000 | ((32'h1 << 8*n) - 1)),
            (32'h80C35A96 | (n << 24)) & (32'h83000000 | ((32'h1 << 8*n) - 1)), "rxcmd");
      ahb(1'b1, `SMBA_OFS_RXCMD, 32'h80000000);
    end
    $display("test writes done");
    for (int i = 0; i < 3; i++) begin
      smb_wr(adr[i], 1, 24'h1, a);
      check(a, i == 0, "address match");
    end
    ahb(1'b1, `SMBA_OFS_RXCMD, 32'h80000000);
    h.start(1'b0);
    h.wbyte({own, 1'b0}, a);
    h.wbyte(8'h21, a);
    h.wbyte(8'h43, a);
    h.start(1'b1);
    h.wbyte({7'h50, 1'b0}, a);
    h.wbyte(8'h65, a);
    ahb(1'b0, `SMBA_OFS_RXCMD, 32'h0);
    check(r[31], 1'b0, "group deferred");
    check(n_exec, 4, "no run before stop");
    h.stop();
    ahb(1'b0, `SMBA_OFS_RXCMD, 32'h0);
    check(r & 32'h8300FFFF, 32'h82004321, "group executed");
    check(n_exec, 5, "one run at stop");
    $display("test addressing and group done");
    ahb(1'b1, `SMBA_OFS_TXDATA, 32'h0000B75E);
    h.start(1'b0);
    h.wbyte({own, 1'b0}, a);
    h.wbyte(8'h8B, a);
    h.start(1'b1);
    h.wbyte({own, 1'b1}, a);
    check(a, 1'b1, "read address ack");
    h.rbyte(1'b0, b);
    check(b, 8'h5E, "low byte");
    h.rbyte(1'b1, b);
    check(b, 8'hB7, "high byte");
    h.stop();
    $display("test read word done");
    ahb(1'b1, `SMBA_OFS_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      fault_in <= 1'b1;
      @(posedge hclk);
      fault_in <= 1'b0;
      repeat (4) @(posedge hclk);
      check(alert_oe, 1'b1, "alert raised");
      smb_wr(own, 1, 24'h1, a);
      check(a, 1'b0, "own address ignored");
      h.start(1'b0);
      h.wbyte({7'h0C, 1'b1}, a);
      check(a, 1'b1, "ara ack");
      if (k == 0) h.rbyte(1'b1, b);
      else h.bit_io(1'b0, x);
      if (k == 1) repeat (8) h.bit_io(1'b1, x);
      h.stop();
      if (k == 0) check(b, {own, 1'b1}, "ara reply");
      check(alert_oe, k == 1, "alert after arbitration");
    end
    smb_wr(own, 1, 24'h1, a);
    check(a, 1'b0, "own ignored after loss");
    ahb(1'b1, `SMBA_OFS_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    check(alert_oe, 1'b0, "alert released when disabled");
    check({hresp, sda_out, alert_out}, 3'b000, "open drain levels");
    $display("test alert done");
    h.start(1'b0);
    h.wbyte({own, 1'b0}, a);
    repeat (3) h.bit_io(1'b1, x);
    h.stop();
    ahb(1'b0, `SMBA_OFS_STATUS, 32'h0);
    check(r[1:0], 2'b11, "cut byte faults");
    check(alert_oe, 1'b0, "no alert while disabled");
    $display("test cut byte done");
    ahb(1'b1, `SMBA_OFS_STATUS, 32'h3);
    h.start(1'b0);
    h.wbyte({own, 1'b0}, a);
    h.hold_low(11000);
    h.stop();
    ahb(1'b0, `SMBA_OFS_STATUS, 32'h0);
    check(r[3:0], 4'h0, "timeout reset, no flags");
    check(n_exec, 5, "no run after cut or timeout");
    $display("test timeout done");
    close_out();
  end
endmodule : smba_slave_tb
`default_nettype wire
